// >>> dmem_defs.vh
// data memory addressing constants: offsets, fields, reset values, bank codes
// assumes inclusion by plain verilog design files of the addressing unit
`ifndef DMEM_DEFS_VH
`define DMEM_DEFS_VH
// ----------------------------------------
// special function register offsets
// ----------------------------------------
`define OFS_INDIRECT_PORT_ZERO  8'h00
`define OFS_POINTER_ZERO        8'h01
`define OFS_INDIRECT_PORT_ONE   8'h02
`define OFS_POINTER_ONE         8'h03
`define OFS_BANK_SELECT         8'h04
`define OFS_WORKING_REGISTER    8'h05
`define OFS_PROGRAM_COUNTER_LOW 8'h06
`define OFS_TABLE_POINTER_LOW   8'h07
`define OFS_TABLE_HIGH_LATCH    8'h08
`define OFS_TABLE_POINTER_HIGH  8'h09
`define OFS_CPU_FLAGS           8'h0a
`define OFS_EEPROM_CONTROL      8'h40
// ----------------------------------------
// map regions
// ----------------------------------------
`define SFR_LAST                8'h7f
`define EXT_SFR_FIRST           8'h0b
// ----------------------------------------
// bank codes and fields
// ----------------------------------------
`define BANK_ZERO               2'h0
`define BANK_ONE                2'h1
`define BANK_TWO                2'h2
`define BANK_UNDEFINED          2'h3
`define BANK_SELECT_RESET       2'h0
`define FLAG_TIMEOUT_BIT        5
`define FLAG_POWER_DOWN_BIT     4
`define FLAG_ARITH_MASK         8'h0f
`define ZERO_BYTE               8'h00
`endif

// >>> dmem_ram.v
// general purpose ram for all three banks, flip-flop storage
// assumes the addressing unit supplies one resolved access per cycle
`timescale 1ns/1ps
module dmem_ram #(
	parameter WORDS = 128,
	parameter BANKS = 3
) (
	input  wire       clk,
	input  wire       wr_en,
	input  wire [1:0] wr_bank,
	input  wire [6:0] wr_addr,
	input  wire [7:0] wr_data,
	input  wire [1:0] rd_bank,
	input  wire [6:0] rd_addr,
	output wire [7:0] rd_data,
	input  wire [6:0] lcd_addr,
	output wire [7:0] lcd_data
);
	reg [7:0] mem [0:BANKS*WORDS-1];

	function integer idx;
		input [1:0] b;
		input [6:0] a;
		begin
			idx = b * WORDS + a;
		end
	endfunction

	always @(posedge clk) begin
		if (wr_en && wr_bank < BANKS) begin
			mem[idx(wr_bank, wr_addr)] <= wr_data;
		end
	end

	assign rd_data  = (rd_bank < BANKS) ? mem[idx(rd_bank, rd_addr)] : 8'h00;
	// display area lives in bank 2, read live by the driver
	assign lcd_data = mem[idx(2'h2, lcd_addr)];
endmodule // dmem_ram

// >>> dmem_addressing.v
// banked data memory addressing: special registers, indirect ports, bank select
// assumes the cpu datapath presents one direct access per cycle, synchronous to clk
`timescale 1ns/1ps
`include "dmem_defs.vh"
// Behaviour
// - memory holds special registers, general ram and display area overlapping by bank
// - display area writes reach display data output with no transfer step
// - special registers decode in all banks except eeprom control at 40h, bank 1 only
// - every bank addresses from 00h
// - indirect port access goes to address held in its pointer; port stores nothing
// - port zero reaches bank 0, port one reaches the selected bank
// - indirect access to a port address reads 00h and writes nothing
// - both pointers are real readable writable registers
// - direct operands always reach bank 0
// - bank select low bits choose bank 0, 1 or 2; 11 undefined
// - reset clears bank select except watchdog reset while powered down
// - bank select bits 7 to 2 read zero
// - unused special register locations read 00
// - writing program counter low byte jumps in page with one dummy cycle
// - table read puts program word high byte in the table high latch
// - flags register holds zero, carry, aux carry, overflow, power down, timeout
// - writes never change power down or timeout flags
module dmem_addressing (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        wdt_powerdown_reset,
	input  wire [7:0]  addr,
	input  wire        rd_en,
	output reg  [7:0]  rd_data,
	input  wire        wr_en,
	input  wire [7:0]  wr_data,
	input  wire        alu_flags_load,
	input  wire [3:0]  alu_flags,
	input  wire        set_timeout,
	input  wire        exec_clear_watchdog,
	input  wire        exec_halt,
	input  wire        tab_read_done,
	input  wire [7:0]  tab_high_byte,
	output wire [15:0] table_address,
	output reg         pc_low_load,
	output reg  [7:0]  pc_low_value,
	output reg         dummy_cycle,
	input  wire [7:0]  ext_sfr_rd_data,
	output wire        ext_sfr_sel,
	output wire        eeprom_control_sel,
	input  wire [6:0]  lcd_addr,
	output wire [7:0]  lcd_data,
	output wire [1:0]  current_bank
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [7:0] pointer_zero;
	reg  [7:0] pointer_one;
	reg  [1:0] bank_select;
	reg  [7:0] working_register;
	reg  [7:0] table_pointer_low;
	reg  [7:0] table_pointer_high;
	reg  [7:0] table_high_byte_latch;
	reg  [3:0] arith_flags;
	reg        power_down_flag;
	reg        watchdog_timeout_flag;

	// ----------------------------------------
	// address resolution
	// ----------------------------------------
	reg  [7:0] eff_addr;
	reg  [1:0] eff_bank;
	reg        port_hit;
	wire       dir_port0 = (addr == `OFS_INDIRECT_PORT_ZERO);
	wire       dir_port1 = (addr == `OFS_INDIRECT_PORT_ONE);
	wire [7:0] ram_rd;
	wire       bank_bad;
	wire       is_sfr_space;
	wire       is_ram;
	wire       is_ee;
	wire       ee_in_bank;
	wire       do_wr;

	always @* begin
		eff_addr = addr;
		eff_bank = `BANK_ZERO;
		port_hit = 1'b0;
		if (dir_port0) begin
			eff_addr = pointer_zero;
			eff_bank = `BANK_ZERO;
			port_hit = 1'b1;
		end else if (dir_port1) begin
			eff_addr = pointer_one;
			eff_bank = bank_select;
			port_hit = 1'b1;
		end
	end

	assign bank_bad     = (eff_bank == `BANK_UNDEFINED);
	assign is_sfr_space = (eff_addr <= `SFR_LAST);
	assign is_ram       = !is_sfr_space && !bank_bad;
	assign is_ee        = (eff_addr == `OFS_EEPROM_CONTROL);
	assign ee_in_bank   = is_ee && (eff_bank == `BANK_ONE);
	assign do_wr        = wr_en && !bank_bad;
	assign current_bank = bank_select;

	// self-reference through a port touches nothing
	wire self_ref = port_hit &&
		(eff_addr == `OFS_INDIRECT_PORT_ZERO || eff_addr == `OFS_INDIRECT_PORT_ONE);

	wire sfr_ok = is_sfr_space && !bank_bad && !self_ref;
	assign ext_sfr_sel = sfr_ok && eff_addr >= `EXT_SFR_FIRST &&
		(!is_ee || ee_in_bank);
	assign eeprom_control_sel = sfr_ok && ee_in_bank;
	assign table_address = {table_pointer_high, table_pointer_low};

	dmem_ram #(
		.WORDS(128),
		.BANKS(3)
	) u_ram (
		.clk      (clk),
		.wr_en    (do_wr && is_ram),
		.wr_bank  (eff_bank),
		.wr_addr  (eff_addr[6:0]),
		.wr_data  (wr_data),
		.rd_bank  (eff_bank),
		.rd_addr  (eff_addr[6:0]),
		.rd_data  (ram_rd),
		.lcd_addr (lcd_addr),
		.lcd_data (lcd_data)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		rd_data = `ZERO_BYTE;
		if (rd_en && !bank_bad && !self_ref) begin
			if (is_ram) begin
				rd_data = ram_rd;
			end else begin
				case (eff_addr)
					`OFS_POINTER_ZERO:        rd_data = pointer_zero;
					`OFS_POINTER_ONE:         rd_data = pointer_one;
					`OFS_BANK_SELECT:         rd_data = {6'h00, bank_select};
					`OFS_WORKING_REGISTER:    rd_data = working_register;
					`OFS_PROGRAM_COUNTER_LOW: rd_data = pc_low_value;
					`OFS_TABLE_POINTER_LOW:   rd_data = table_pointer_low;
					`OFS_TABLE_HIGH_LATCH:    rd_data = table_high_byte_latch;
					`OFS_TABLE_POINTER_HIGH:  rd_data = table_pointer_high;
					`OFS_CPU_FLAGS:           rd_data = {2'h0, watchdog_timeout_flag,
						power_down_flag, arith_flags};
					default:                  rd_data = ext_sfr_sel ? ext_sfr_rd_data : `ZERO_BYTE;
				endcase
			end
		end
	end

	wire sfr_wr = do_wr && sfr_ok;

	// ----------------------------------------
	// bank select
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			if (!wdt_powerdown_reset) begin
				bank_select <= `BANK_SELECT_RESET;
			end
		end else if (sfr_wr && eff_addr == `OFS_BANK_SELECT) begin
			bank_select <= wr_data[1:0];
		end
	end

	// ----------------------------------------
	// pointers, working and table registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			pointer_zero          <= 8'h00;
			pointer_one           <= 8'h00;
			working_register      <= 8'h00;
			table_pointer_low     <= 8'h00;
			table_pointer_high    <= 8'h00;
			table_high_byte_latch <= 8'h00;
		end else begin
			if (sfr_wr && eff_addr == `OFS_POINTER_ZERO) begin
				pointer_zero <= wr_data;
			end
			if (sfr_wr && eff_addr == `OFS_POINTER_ONE) begin
				pointer_one <= wr_data;
			end
			if (sfr_wr && eff_addr == `OFS_WORKING_REGISTER) begin
				working_register <= wr_data;
			end
			if (sfr_wr && eff_addr == `OFS_TABLE_POINTER_LOW) begin
				table_pointer_low <= wr_data;
			end
			if (sfr_wr && eff_addr == `OFS_TABLE_POINTER_HIGH) begin
				table_pointer_high <= wr_data;
			end
			if (tab_read_done) begin
				table_high_byte_latch <= tab_high_byte;
			end
		end
	end

	// ----------------------------------------
	// program counter low byte
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			pc_low_value <= 8'h00;
			pc_low_load  <= 1'b0;
			dummy_cycle  <= 1'b0;
		end else begin
			pc_low_load <= 1'b0;
			dummy_cycle <= pc_low_load;
			if (sfr_wr && eff_addr == `OFS_PROGRAM_COUNTER_LOW) begin
				pc_low_value <= wr_data;
				pc_low_load  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// cpu flags
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			arith_flags           <= 4'h0;
			if (!wdt_powerdown_reset) begin
				power_down_flag       <= 1'b0;
				watchdog_timeout_flag <= 1'b0;
			end else begin
				watchdog_timeout_flag <= 1'b1;
			end
		end else begin
			if (sfr_wr && eff_addr == `OFS_CPU_FLAGS) begin
				arith_flags <= wr_data[3:0];
			end else if (alu_flags_load) begin
				arith_flags <= alu_flags;
			end
			if (exec_halt) begin
				power_down_flag       <= 1'b1;
				watchdog_timeout_flag <= 1'b0;
			end else if (exec_clear_watchdog) begin
				power_down_flag       <= 1'b0;
				watchdog_timeout_flag <= 1'b0;
			end
			if (set_timeout) begin
				watchdog_timeout_flag <= 1'b1;
			end
		end
	end
endmodule // dmem_addressing

// >>> cpu_side_model.sv
// far side model: peripheral register read data and program word high byte
// assumes the addressing unit drives table_address and ext_sfr_sel
`timescale 1ns/1ps
module cpu_side_model (
	input  wire        ext_sfr_sel,
	input  wire [15:0] table_address,
	output wire [7:0]  ext_sfr_rd_data,
	output wire [7:0]  tab_high_byte
);
	// unselected bus shows the inverted pattern
	assign ext_sfr_rd_data = ext_sfr_sel ? 8'hc3 : 8'h3c;
	// program word high byte follows the pointer pair
	assign tab_high_byte = table_address[15:8] ^ table_address[7:0] ^ 8'ha0;
endmodule // cpu_side_model

// >>> dmem_addressing_chk.sv
// port checker for the data memory addressing unit
// assumes one clock clk and synchronous active-low reset rst_b
`timescale 1ns/1ps
module dmem_addressing_chk (
	input wire       clk,
	input wire       rst_b,
	input wire       wdt_powerdown_reset,
	input wire [7:0] addr,
	input wire       rd_en,
	input wire [7:0] rd_data,
	input wire       wr_en,
	input wire [7:0] wr_data,
	input wire       set_timeout,
	input wire       exec_clear_watchdog,
	input wire       exec_halt,
	input wire       tab_read_done,
	input wire [7:0] tab_high_byte,
	input wire       pc_low_load,
	input wire [7:0] pc_low_value,
	input wire       dummy_cycle,
	input wire       ext_sfr_sel,
	input wire       eeprom_control_sel,
	input wire [1:0] current_bank
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire quiet = !set_timeout && !exec_halt && !exec_clear_watchdog;
	chk_pcl_jump: assert property (wr_en && addr == 8'h06 |=>
		pc_low_load && pc_low_value == $past(wr_data)) else $error("pcl jump");
	chk_dummy_slot: assert property (pc_low_load |=> dummy_cycle) else $error("dummy");
	chk_bank_read: assert property (rd_en && addr == 8'h04 |->
		rd_data == {6'h00, current_bank}) else $error("bank read");
	chk_bank_write: assert property (wr_en && addr == 8'h04 |=>
		current_bank == $past(wr_data[1:0])) else $error("bank write");
	chk_bank_reset: assert property (rst_b && !$past(rst_b) && !$past(wdt_powerdown_reset) |->
		current_bank == 2'h0) else $error("bank reset");
	chk_bank_keep: assert property (rst_b && !$past(rst_b) && $past(wdt_powerdown_reset)
		&& $past(rst_b, 2) |-> current_bank == $past(current_bank)) else $error("bank keep");
	chk_flag_guard: assert property (rd_en && addr == 8'h0a
		&& $past(rd_en && addr == 8'h0a && quiet && rst_b) |-> rd_data[5:4] == $past(rd_data[5:4]))
		else $error("flag guard");
	chk_tab_latch: assert property (rd_en && addr == 8'h08 && $past(tab_read_done) |->
		rd_data == $past(tab_high_byte)) else $error("tab latch");
	chk_direct_bank: assert property (rd_en && addr == 8'h40 |->
		!eeprom_control_sel && !ext_sfr_sel) else $error("direct bank");
	cover property (dummy_cycle);
	cover property (eeprom_control_sel);
	cover property (current_bank == 2'h2);
endmodule // dmem_addressing_chk
bind dmem_addressing dmem_addressing_chk u_chk (.*);

// >>> tb_top.sv
// self-checking bench for the data memory addressing unit
// assumes dmem_addressing, its checker and cpu_side_model are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	reg         clk = 1'b0, rst_b = 1'b0, wdt_powerdown_reset = 1'b0;
	reg         rd_en = 1'b0, wr_en = 1'b0, tab_read_done = 1'b0, alu_flags_load = 1'b0;
	reg         set_timeout = 1'b0, exec_clear_watchdog = 1'b0, exec_halt = 1'b0;
	reg  [7:0]  addr = 8'h00, wr_data = 8'h00;
	reg  [3:0]  alu_flags = 4'h5;
	reg  [6:0]  lcd_addr = 7'h10;
	wire [7:0]  rd_data, pc_low_value, ext_sfr_rd_data, tab_high_byte, lcd_data;
	wire [15:0] table_address;
	wire [1:0]  current_bank;
	wire        pc_low_load, dummy_cycle, ext_sfr_sel, eeprom_control_sel;
	integer     mismatches = 0, checks = 0, b;
	always #2 clk = ~clk;
	dmem_addressing dut (.*);
	cpu_side_model partner (.*);
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge clk);
			addr = a;
			wr_data = d;
			wr_en = 1'b1;
			@(negedge clk);
			wr_en = 1'b0;
		end
	endtask
	task chk_rd(input [7:0] a, input [7:0] e);
		begin
			@(negedge clk);
			addr = a;
			rd_en = 1'b1;
			#1;
			`CHK(rd_data, e)
		end
	endtask
	task pulse(input [4:0] e);
		begin
			@(negedge clk);
			{tab_read_done, alu_flags_load, set_timeout, exec_halt, exec_clear_watchdog} = e;
			@(negedge clk);
			{tab_read_done, alu_flags_load, set_timeout, exec_halt, exec_clear_watchdog} = 5'h00;
		end
	endtask
	task do_reset(input w);
		begin
			@(negedge clk);
			rst_b = 1'b0;
			wdt_powerdown_reset = w;
			@(negedge clk);
			rst_b = 1'b1;
			wdt_powerdown_reset = 1'b0;
		end
	endtask
	task end_of_test;
		begin
			$display("mismatches=%0d checks=%0d", mismatches, checks);
			if (mismatches == 0 && checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		#20000;
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk_rd(8'h04, 8'h00);
		wr(8'h01, 8'h90);
		chk_rd(8'h01, 8'h90);
		for (b = 0; b < 3; b++) begin
			wr(8'h04, b[7:0]);
			wr(8'h03, 8'h90);
			wr(8'h02, 8'h10 + b[7:0]);
		end
		chk_rd(8'h90, 8'h10);
		chk_rd(8'h00, 8'h10);
		wr(8'h02, 8'h5a);
		#1 `CHK(lcd_data, 8'h5a)
		wr(8'h00, 8'h33);
		chk_rd(8'h90, 8'h33);
		for (b = 1; b < 3; b++) begin
			wr(8'h04, b[7:0]);
			chk_rd(8'h02, (b == 1) ? 8'h11 : 8'h5a);
		end
		wr(8'h04, 8'hff);
		chk_rd(8'h04, 8'h03);
		wr(8'h02, 8'h77);
		chk_rd(8'h02, 8'h00);
		wr(8'h04, 8'h01);
		chk_rd(8'h02, 8'h11);
		wr(8'h03, 8'h02);
		chk_rd(8'h02, 8'h00);
		wr(8'h02, 8'hee);
		chk_rd(8'h03, 8'h02);
		wr(8'h03, 8'h40);
		chk_rd(8'h02, 8'hc3);
		`CHK(eeprom_control_sel, 1'b1)
		wr(8'h04, 8'h00);
		chk_rd(8'h02, 8'h00);
		chk_rd(8'h40, 8'h00);
		chk_rd(8'h0b, 8'hc3);
		wr(8'h06, 8'h3c);
		`CHK({pc_low_load, pc_low_value}, 9'h13c)
		@(negedge clk);
		`CHK(dummy_cycle, 1'b1)
		wr(8'h07, 8'h06);
		wr(8'h09, 8'h0f);
		`CHK(table_address, 16'h0f06)
		chk_rd(8'h08, 8'h00);
		pulse(5'h10);
		wr(8'h08, 8'hff);
		chk_rd(8'h08, 8'ha9);
		pulse(5'h08);
		chk_rd(8'h0a, 8'h05);
		pulse(5'h02);
		chk_rd(8'h0a, 8'h15);
		pulse(5'h04);
		chk_rd(8'h0a, 8'h35);
		wr(8'h0a, 8'hca);
		chk_rd(8'h0a, 8'h3a);
		pulse(5'h01);
		chk_rd(8'h0a, 8'h0a);
		wr(8'h04, 8'h02);
		do_reset(1'b1);
		chk_rd(8'h04, 8'h02);
		chk_rd(8'h0a, 8'h20);
		do_reset(1'b0);
		chk_rd(8'h04, 8'h00);
		end_of_test;
	end
endmodule // tb_top
